// >>> rtl/wtrsm_pkg.sv
// Constants, offsets and types shared by the watchdog timer.
package wtrsm_pkg;

    // ==========================================================
    // Register bus
    localparam int          ADDR_W    = 4;
    localparam logic [3:0]  CTL_OFS   = 4'h0;
    localparam logic [3:0]  RLD_U_OFS = 4'h1;
    localparam logic [3:0]  RLD_H_OFS = 4'h2;
    localparam logic [3:0]  RLD_L_OFS = 4'h3;

    // ==========================================================
    // Control register fields
    localparam int CTL_TO_BIT   = 7;
    localparam int CTL_STOP_BIT = 6;
    localparam int CTL_SDIS_BIT = 0;

    // ==========================================================
    // Control register key values
    localparam logic [7:0] KEY_FIRST    = 8'h55;
    localparam logic [7:0] KEY_SECOND   = 8'haa;
    localparam logic [7:0] STOP_OFF_KEY = 8'h81;
    localparam logic [7:0] STOP_ON_KEY  = 8'h00;

    // ==========================================================
    // Counter values
    localparam logic [23:0] RELOAD_RST    = 24'hffffff;
    localparam logic [23:0] REFRESH_FLOOR = 24'h000002;
    localparam logic [23:0] TERMINAL_CNT  = 24'h000001;
    localparam logic [23:0] MIN_RELOAD    = 24'h000004;

    // ==========================================================
    // Timing
    localparam int MCLK_PERIOD_NS = 10;
    localparam int RC_PERIOD_NS   = 100000;
    localparam int RC_DIV_CYC     = RC_PERIOD_NS / MCLK_PERIOD_NS;
    localparam int DIV_W          = 14;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_KEY1,
        SEQ_OPEN
    } wtrsm_seq_t;

    typedef struct packed {
        logic              on;
        logic [23:0]       cnt;
        logic [7:0]        rld_u;
        logic [7:0]        rld_h;
        logic [7:0]        rld_l;
        logic [DIV_W-1:0]  div;
        logic              to_flag;
        logic              stop_flag;
        logic              stop_dis;
        wtrsm_seq_t        seq;
        logic [7:0]        rdata;
        logic              rst_req;
        logic              irq;
        logic              recover;
    } wtrsm_state_t;

endpackage

// >>> rtl/wtrsm_top.sv
// Watchdog timer with RC time base, lock sequence and STOP-mode control.
//
// The implementer's own choices: the address-and-strobe port and the address map.
module wtrsm_top #(
    parameter int RC_DIV = wtrsm_pkg::RC_DIV_CYC
) (
    // Clock and reset
    input  wire logic                        mclk,
    input  wire logic                        rstn,
    // Register port
    input  wire logic [wtrsm_pkg::ADDR_W-1:0] addr,
    input  wire logic [7:0]                  wdata,
    input  wire logic                        wr,
    input  wire logic                        rd,
    output logic      [7:0]                  rdata,
    // Core and option inputs
    input  wire logic                        refresh,
    input  wire logic                        always_on_option,
    input  wire logic                        timeout_reset_option,
    input  wire logic                        stop_mode,
    // Watchdog events
    output logic                             wdt_reset_req,
    output logic                             wdt_irq,
    output logic                             stop_recover,
    output logic                             wdt_running
);

    localparam logic [wtrsm_pkg::DIV_W-1:0] DIV_LAST = wtrsm_pkg::DIV_W'(RC_DIV - 1);

    wtrsm_pkg::wtrsm_state_t q;
    wtrsm_pkg::wtrsm_state_t s;
    logic                    osc_run;
    logic                    tick;
    logic [23:0]             reload_val;

    // ==========================================================
    // Time base and next state
    always_comb
    begin
        s          = q;
        s.rdata    = 8'h00;
        s.rst_req  = 1'b0;
        s.irq      = 1'b0;
        s.recover  = 1'b0;
        reload_val = {q.rld_u, q.rld_h, q.rld_l};
        // The RC time base halts only in STOP mode with the disable set.
        osc_run    = !(stop_mode && q.stop_dis);
        tick       = osc_run && (q.div == DIV_LAST);

        if (!osc_run || tick)
        begin
            s.div = '0;
        end
        else
        begin
            s.div = q.div + wtrsm_pkg::DIV_W'(1);
        end

        // Control register reads clear the status bits before new events set them.
        if (rd)
        begin
            case (addr)
                wtrsm_pkg::CTL_OFS:
                begin
                    s.rdata[wtrsm_pkg::CTL_TO_BIT]   = q.to_flag;
                    s.rdata[wtrsm_pkg::CTL_STOP_BIT] = q.stop_flag;
                    s.rdata[wtrsm_pkg::CTL_SDIS_BIT] = q.stop_dis;
                    s.to_flag   = 1'b0;
                    s.stop_flag = 1'b0;
                end
                wtrsm_pkg::RLD_U_OFS: s.rdata = q.rld_u;
                wtrsm_pkg::RLD_H_OFS: s.rdata = q.rld_h;
                wtrsm_pkg::RLD_L_OFS: s.rdata = q.rld_l;
                default:              s.rdata = 8'h00;
            endcase
        end

        if (wr)
        begin
            case (addr)
                wtrsm_pkg::CTL_OFS:
                begin
                    // Key writes only advance the sequence.
                    case (q.seq)
                        wtrsm_pkg::SEQ_IDLE:
                        begin
                            s.seq = (wdata == wtrsm_pkg::KEY_FIRST) ?
                                    wtrsm_pkg::SEQ_KEY1 : wtrsm_pkg::SEQ_IDLE;
                        end
                        wtrsm_pkg::SEQ_KEY1:
                        begin
                            if (wdata == wtrsm_pkg::KEY_SECOND)
                            begin
                                s.seq = wtrsm_pkg::SEQ_OPEN;
                            end
                            else if (wdata == wtrsm_pkg::KEY_FIRST)
                            begin
                                s.seq = wtrsm_pkg::SEQ_KEY1;
                            end
                            else
                            begin
                                s.seq = wtrsm_pkg::SEQ_IDLE;
                            end
                        end
                        wtrsm_pkg::SEQ_OPEN:
                        begin
                            if (wdata == wtrsm_pkg::STOP_OFF_KEY)
                            begin
                                s.stop_dis = 1'b1;
                            end
                            else if (wdata == wtrsm_pkg::STOP_ON_KEY)
                            begin
                                s.stop_dis = 1'b0;
                            end
                            s.seq = wtrsm_pkg::SEQ_IDLE;
                        end
                        default: s.seq = wtrsm_pkg::SEQ_IDLE;
                    endcase
                end
                wtrsm_pkg::RLD_U_OFS:
                begin
                    if (q.seq == wtrsm_pkg::SEQ_OPEN)
                    begin
                        s.rld_u = wdata;
                    end
                end
                wtrsm_pkg::RLD_H_OFS:
                begin
                    if (q.seq == wtrsm_pkg::SEQ_OPEN)
                    begin
                        s.rld_h = wdata;
                    end
                end
                wtrsm_pkg::RLD_L_OFS:
                begin
                    if (q.seq == wtrsm_pkg::SEQ_OPEN)
                    begin
                        s.rld_l = wdata;
                        s.seq   = wtrsm_pkg::SEQ_IDLE;
                    end
                end
                default: s.seq = q.seq;
            endcase
        end

        // ==========================================================
        // Counter
        if (!q.on)
        begin
            if (always_on_option || refresh)
            begin
                s.on  = 1'b1;
                s.cnt = reload_val;
            end
        end
        else if (refresh && (q.cnt > wtrsm_pkg::REFRESH_FLOOR))
        begin
            s.cnt = reload_val;
        end
        else if (tick)
        begin
            // A reload at or under the refresh floor of 2 leaves no refresh window.
            if (q.cnt <= wtrsm_pkg::TERMINAL_CNT)
            begin
                s.cnt = reload_val;
                if (timeout_reset_option)
                begin
                    s.to_flag = 1'b1;
                    if (stop_mode)
                    begin
                        s.stop_flag = 1'b1;
                        s.recover   = 1'b1;
                    end
                    else
                    begin
                        s.rst_req = 1'b1;
                    end
                end
                else
                begin
                    s.irq     = 1'b1;
                    s.recover = stop_mode;
                end
            end
            else
            begin
                s.cnt = q.cnt - 24'h000001;
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            q          <= '0;
            q.rld_u    <= wtrsm_pkg::RELOAD_RST[23:16];
            q.rld_h    <= wtrsm_pkg::RELOAD_RST[15:8];
            q.rld_l    <= wtrsm_pkg::RELOAD_RST[7:0];
            q.cnt      <= wtrsm_pkg::RELOAD_RST;
            q.stop_dis <= 1'b0;
            q.seq      <= wtrsm_pkg::SEQ_IDLE;
        end
        else
        begin
            q <= s;
        end
    end

    assign rdata         = q.rdata;
    assign wdt_reset_req = q.rst_req;
    assign wdt_irq       = q.irq;
    assign stop_recover  = q.recover;
    assign wdt_running   = q.on;

    // ==========================================================
    // Checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    sequence s_key_first;
        wr && (addr == wtrsm_pkg::CTL_OFS) && (wdata == wtrsm_pkg::KEY_FIRST);
    endsequence
    sequence s_key_start;
        wr && (addr == wtrsm_pkg::CTL_OFS) && (wdata == wtrsm_pkg::KEY_FIRST)
            && (q.seq != wtrsm_pkg::SEQ_OPEN);
    endsequence
    sequence s_key_second;
        wr && (addr == wtrsm_pkg::CTL_OFS) && (wdata == wtrsm_pkg::KEY_SECOND);
    endsequence
    sequence s_key_off;
        wr && (addr == wtrsm_pkg::CTL_OFS) && (wdata == wtrsm_pkg::STOP_OFF_KEY);
    endsequence
    sequence s_timeout;
        q.on && tick && !(refresh && (q.cnt > wtrsm_pkg::REFRESH_FLOOR))
            && (q.cnt <= wtrsm_pkg::TERMINAL_CNT);
    endsequence

    chk_unlock_opens:   assert property (s_key_start ##1 s_key_second |=>
        (q.seq == wtrsm_pkg::SEQ_OPEN)) else $error("unlock did not open reload bytes");
    chk_stop_disable:   assert property (s_key_start ##1 s_key_second ##1 s_key_off
        |=> q.stop_dis) else $error("stop disable sequence not taken");
    chk_key_bits_hold:  assert property ((s_key_first or s_key_second)
        |=> $stable(q.stop_dis)) else $error("key write changed control bits");
    chk_locked_upper:   assert property (wr && (addr == wtrsm_pkg::RLD_U_OFS)
        && (q.seq != wtrsm_pkg::SEQ_OPEN) |=> $stable(q.rld_u))
        else $error("locked reload byte was written");
    chk_low_relocks:    assert property (wr && (addr == wtrsm_pkg::RLD_L_OFS)
        && (q.seq == wtrsm_pkg::SEQ_OPEN) |=> (q.seq == wtrsm_pkg::SEQ_IDLE))
        else $error("reload not relocked");
    chk_refresh_loads:  assert property (q.on && refresh
        && (q.cnt > wtrsm_pkg::REFRESH_FLOOR) |=> (q.cnt == $past(reload_val)))
        else $error("refresh did not reload counter");
    chk_refresh_late:   assert property (q.on && refresh && !tick
        && (q.cnt <= wtrsm_pkg::REFRESH_FLOOR) |=> $stable(q.cnt))
        else $error("late refresh was accepted");
    chk_timeout_reset:  assert property (s_timeout and (timeout_reset_option && !stop_mode)
        |=> wdt_reset_req && q.to_flag && !wdt_irq) else $error("reset timeout missing");
    chk_stop_timeout:   assert property (s_timeout and (timeout_reset_option && stop_mode)
        |=> stop_recover && q.to_flag && q.stop_flag) else $error("stop timeout missing");
    chk_timeout_irq:    assert property (s_timeout and !timeout_reset_option
        |=> wdt_irq && !wdt_reset_req && (stop_recover == $past(stop_mode)))
        else $error("interrupt timeout missing");
    chk_always_on:      assert property (always_on_option |=> wdt_running)
        else $error("always-on option did not start counter");
    chk_stays_on:       assert property (wdt_running |=> wdt_running)
        else $error("watchdog turned off");
    chk_stop_freeze:    assert property (q.on && stop_mode && q.stop_dis && !refresh
        |=> $stable(q.cnt)) else $error("counter ran in STOP with disable set");
    // Cycles of running time base since the last tick, kept apart from the divider.
    logic [wtrsm_pkg::DIV_W-1:0] gap_r;

    always_ff @(posedge mclk)
    begin
        if (!rstn || !osc_run || tick)
        begin
            gap_r <= '0;
        end
        else
        begin
            gap_r <= gap_r + wtrsm_pkg::DIV_W'(1);
        end
    end

    chk_tick_period:    assert property (osc_run |-> (tick == (gap_r == DIV_LAST)))
        else $error("tick period broken");

endmodule

// >>> testbench/wtrsm_cpu.sv
// Processor-side partner: register accesses and refresh instructions.
module wtrsm_cpu (
    // Clock and read data
    input  wire logic       mclk,
    input  wire logic [7:0] rdata,
    // Register port and refresh
    output logic      [3:0] addr,
    output logic      [7:0] wdata,
    output logic            wr,
    output logic            rd,
    output logic            refresh
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        addr    = 4'h0;
        wdata   = 8'h00;
        wr      = 1'b0;
        rd      = 1'b0;
        refresh = 1'b0;
    end

    bit chained = 1'b0;

    // A released bus shows the inverse of its last value, never a stale copy.
    // A chained write keeps the strobe up so the next write follows with no gap.
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] v, input bit more);
        if (!chained)
        begin
            @(posedge mclk);
        end
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge mclk);
        chained = more;
        if (!more)
        begin
            wr    <= 1'b0;
            addr  <= ~a;
            wdata <= ~v;
        end
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd   <= 1'b0;
        addr <= ~a;
        @(negedge mclk);
        v = rdata;
    endtask

    task automatic kick();
        @(posedge mclk);
        refresh <= 1'b1;
        @(posedge mclk);
        refresh <= 1'b0;
    endtask

    task automatic load(input logic [23:0] v);
        if (v < 24'h000004)
            v = 24'h000004;
        wr_reg(4'h0, 8'h55, 1'b1);
        wr_reg(4'h0, 8'haa, 1'b1);
        wr_reg(4'h1, v[23:16], 1'b1);
        wr_reg(4'h2, v[15:8], 1'b1);
        wr_reg(4'h3, v[7:0], 1'b0);
    endtask

    task automatic stop_cfg(input logic off);
        wr_reg(4'h0, 8'h55, 1'b1);
        wr_reg(4'h0, 8'haa, 1'b1);
        wr_reg(4'h0, off ? 8'h81 : 8'h00, 1'b0);
    endtask
endmodule

// >>> testbench/watchdog_timer_rc_stop_mode_test.sv
// Self-checking bench for the watchdog timer against an integer model.
`define check_eq(got, exp) \
    begin \
        checks++; \
        if ((got) !== (exp)) \
        begin \
            n_mismatch++; \
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp); \
        end \
    end

module watchdog_timer_rc_stop_mode_test;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int D = 10;
    logic       mclk;
    logic       rstn;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic       refresh;
    logic       always_on_option;
    logic       timeout_reset_option;
    logic       stop_mode;
    logic       wdt_reset_req;
    logic       wdt_irq;
    logic       stop_recover;
    logic       wdt_running;
    int         n_mismatch = 0;
    int         checks = 0;
    int         seq;
    int         sd;
    int         to_f;
    int         st_f;
    int         rl;
    int         rb[$];

    wtrsm_top #(.RC_DIV(D)) dut (.mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .refresh(refresh),
        .always_on_option(always_on_option), .timeout_reset_option(timeout_reset_option),
        .stop_mode(stop_mode), .wdt_reset_req(wdt_reset_req), .wdt_irq(wdt_irq),
        .stop_recover(stop_recover), .wdt_running(wdt_running));

    wtrsm_cpu cpu (.mclk(mclk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .refresh(refresh));

    initial
    begin
        mclk                 = 1'b0;
        rstn                 = 1'b0;
        always_on_option     = 1'b0;
        timeout_reset_option = 1'b0;
        stop_mode            = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // ==========================================================
    // Model
    function automatic void m_wr(input int a, input int v);
        if (a == 0)
        begin
            if (seq == 2)
            begin
                sd  = (v == 8'h81) ? 1 : (v == 0) ? 0 : sd;
                seq = 0;
            end
            else
                seq = (v == 8'h55) ? 1 : (seq == 1 && v == 8'haa) ? 2 : (v == 8'h55) ? 1 : 0;
        end
        else if (seq == 2 && a <= 3)
        begin
            rb[a] = v;
            seq   = (a == 3) ? 0 : 2;
        end
    endfunction

    function automatic logic [7:0] m_ctl();
        return {to_f[0], st_f[0], 5'h00, sd[0]};
    endfunction

    // ==========================================================
    // Stimulus tasks
    task automatic w(input int a, input int v);
        m_wr(a, v);
        cpu.wr_reg(a[3:0], v[7:0], 1'b0);
    endtask

    task automatic rchk(input logic [3:0] a);
        logic [7:0] v;
        logic [7:0] e;
        e = (a == 4'h0) ? m_ctl() : (a <= 4'h3) ? rb[a][7:0] : 8'h00;
        cpu.rd_reg(a, v);
        `check_eq(v, e)
        if (a == 4'h0)
        begin
            to_f = 0;
            st_f = 0;
        end
    endtask

    task automatic mode(input logic ro, input logic sm);
        @(posedge mclk);
        timeout_reset_option <= ro;
        stop_mode            <= sm;
    endtask

    task automatic do_reset(input logic ao);
        @(posedge mclk);
        rstn             <= 1'b0;
        always_on_option <= ao;
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
        seq  = 0;
        sd   = 0;
        to_f = 0;
        st_f = 0;
        rb   = '{0, 255, 255, 255};
        repeat (3) @(negedge mclk);
    endtask

    task automatic expect_to(input int lo, input int hi);
        int         n;
        logic [2:0] got;
        logic [2:0] exp;
        n   = 0;
        got = 3'b000;
        exp = timeout_reset_option ? {~stop_mode, 1'b0, stop_mode} : {2'b01, stop_mode};
        while (got == 3'b000 && n <= hi)
        begin
            @(negedge mclk);
            n++;
            got = {wdt_reset_req, wdt_irq, stop_recover};
        end
        `check_eq(got, exp)
        `check_eq(n > lo && n <= hi, 1'b1)
        if (timeout_reset_option)
        begin
            to_f = 1;
            st_f = st_f | stop_mode;
        end
    endtask

    task automatic tmo();
        rl = rb[1] * 65536 + rb[2] * 256 + rb[3];
        cpu.kick();
        expect_to((rl - 1) * D, rl * D + 3);
    endtask

    task automatic quiet(input int n);
        int bad;
        bad = 0;
        repeat (n)
        begin
            @(negedge mclk);
            bad += ((wdt_reset_req | wdt_irq | stop_recover) !== 1'b0) ? 1 : 0;
        end
        `check_eq(bad, 0)
    endtask

    task automatic sdis(input int off);
        m_wr(0, 8'h55);
        m_wr(0, 8'haa);
        m_wr(0, off ? 8'h81 : 8'h00);
        cpu.stop_cfg(off != 0);
    endtask

    task automatic complete_run();
        $display("mismatches %0d of %0d checks", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        repeat (40000) @(posedge mclk);
        n_mismatch++;
        $display("mismatch at %0t: run did not finish in time", $time);
        complete_run();
    end

    // ==========================================================
    // Main sequence
    initial
    begin
        void'($urandom(32'ha6aa));
        do_reset(1'b0);
        `check_eq(wdt_running, 1'b0)
        rchk(4'h0);
        rchk(4'h9);
        w(3, 5);
        w(1, $urandom_range(255));
        rchk(4'h1);
        rchk(4'h3);
        w(0, 8'h55);
        w(12, $urandom_range(255));
        w(0, 8'haa);
        rchk(4'h0);
        w(1, 0);
        w(2, 0);
        w(3, 12 + $urandom_range(8));
        w(3, 3);
        rchk(4'h3);
        tmo();
        expect_to(rl * D - 2, rl * D + 2);
        rchk(4'h0);
        cpu.kick();
        quiet((rl - 2) * D + 3);
        cpu.kick();
        expect_to(D - 6, 2 * D);
        repeat (4)
        begin
            cpu.kick();
            quiet((rl - 4) * D);
        end
        mode(1'b1, 1'b0);
        tmo();
        rchk(4'h0);
        rchk(4'h0);
        mode(1'b1, 1'b1);
        tmo();
        rchk(4'h0);
        mode(1'b0, 1'b1);
        tmo();
        sdis(1);
        rchk(4'h0);
        quiet(3 * rl * D);
        mode(1'b0, 1'b0);
        tmo();
        mode(1'b0, 1'b1);
        sdis(0);
        rchk(4'h0);
        tmo();
        mode(1'b0, 1'b0);
        m_wr(0, 8'h55);
        m_wr(0, 8'haa);
        m_wr(1, 0);
        m_wr(2, 1);
        m_wr(3, $urandom_range(255));
        cpu.load({8'h00, 8'h01, rb[3][7:0]});
        rchk(4'h2);
        tmo();
        do_reset(1'b1);
        `check_eq(wdt_running, 1'b1)
        do_reset(1'b0);
        `check_eq(wdt_running, 1'b0)
        complete_run();
    end
endmodule
